// *** ttd_top.sv ***
/*
 External TTL trigger detector with its AXI4-Lite register slave.
 Assumes acquisition logic on the same clock gives an arm pulse and an internal trigger;
 the connector pin is resolved from out and enable outside this module.
*/
// Register access over AXI4-Lite was decided locally.
module ttd_top
    import ttd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ttd_axi_req_t axi_req,
    output ttd_axi_rsp_t axi_rsp,
    input wire logic trig_conn_in,
    output logic trig_conn_out,
    output logic trig_conn_oe,
    input wire logic extra_in0,
    input wire logic extra_in1,
    output logic term_50_en,
    input wire logic acq_arm,
    input wire logic internal_trig,
    output logic trig_pulse,
    output logic armed
);
    typedef struct packed {
        logic [31:0] out_enable;
        logic [31:0] termination;
        logic [31:0] or_mask;
        logic [31:0] main_mode;
        logic [31:0] extra0_mode;
        logic [31:0] extra1_mode;
        logic armed;
        logic trig;
        logic conn_out;
        logic conn_oe;
        logic term_en;
        logic [ADDR_W-1:0] aw_addr;
        logic aw_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_held;
        ttd_axi_rsp_t rsp;
    } ttd_top_state_t;

    ttd_top_state_t st;
    ttd_top_state_t next_st;
    logic [2:0] hits;
    logic [2:0] enabled;
    logic fire;
    logic ext_mode_on;
    logic [31:0] avail_modes;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;

    // Merge byte lanes of a write into an old register value
    function automatic logic [31:0] ttd_merge(input logic [31:0] old_val,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : ttd_merge

    // A mode value is accepted only when the hardware supports it
    function automatic logic ttd_mode_ok(input logic [31:0] m, input logic [31:0] avail);
        logic [31:0] base;
        logic ok;
        base = m & ~PULSE_STRETCH_FLAG;
        ok = ((m & ~avail) == 32'h0);
        if ((m & PULSE_STRETCH_FLAG) != 32'h0)
        begin
            ok = ok && ((base == RISING_EDGE_MODE) || (base == FALLING_EDGE_MODE));
        end
        return ok;
    endfunction : ttd_mode_ok

    // Supported modes, stretch bit only where fitted
    assign avail_modes = RISING_EDGE_MODE | FALLING_EDGE_MODE | ANY_EDGE_MODE
        | HIGH_LEVEL_MODE | LOW_LEVEL_MODE
        | (STRETCH_FITTED ? PULSE_STRETCH_FLAG : 32'h0);

    // One detector per TTL source, each with its own mode
    ttd_in_det u_det_main (
        .clk(clk),
        .rst_b(rst_b),
        .pin(trig_conn_in),
        .mode(st.main_mode),
        .armed(st.armed),
        .hit(hits[0])
    );

    ttd_in_det u_det_extra0 (
        .clk(clk),
        .rst_b(rst_b),
        .pin(extra_in0),
        .mode(st.extra0_mode),
        .armed(st.armed),
        .hit(hits[1])
    );

    ttd_in_det u_det_extra1 (
        .clk(clk),
        .rst_b(rst_b),
        .pin(extra_in1),
        .mode(st.extra1_mode),
        .armed(st.armed),
        .hit(hits[2])
    );

    // Or-mask gating of each source
    assign enabled[0] = st.or_mask[MASK_MAIN_BIT];
    assign enabled[1] = EXTRA_IN_FITTED && st.or_mask[MASK_EXTRA0_BIT];
    assign enabled[2] = EXTRA_IN_FITTED && st.or_mask[MASK_EXTRA1_BIT];
    assign fire = st.armed && ((hits & enabled) != 3'b000);
    assign ext_mode_on = (st.main_mode != INPUT_UNUSED_MODE);

    // Bus handshakes and the write held so far
    assign aw_take = axi_req.awvalid && st.rsp.awready;
    assign w_take = axi_req.wvalid && st.rsp.wready;
    assign ar_take = axi_req.arvalid && st.rsp.arready;
    assign have_aw = st.aw_held || aw_take;
    assign have_w = st.w_held || w_take;
    assign wr_addr = st.aw_held ? st.aw_addr : axi_req.awaddr;
    assign wr_data = st.w_held ? st.w_data : axi_req.wdata;
    assign wr_strb = st.w_held ? st.w_strb : axi_req.wstrb;
    assign wr_idx = wr_addr[ADDR_W-1:2];
    assign rd_idx = axi_req.araddr[ADDR_W-1:2];

    // Next state of registers, trigger logic and bus slave
    always_comb
    begin
        next_st = st;
        // Trigger: one pulse, then stay disarmed until the next arm
        next_st.trig = fire;
        if (fire)
        begin
            next_st.armed = 1'b0;
        end
        else if (acq_arm)
        begin
            next_st.armed = 1'b1;
        end
        // Connector: input only in external mode, else optional trigger out
        next_st.conn_oe = st.out_enable[0] && !ext_mode_on;
        next_st.conn_out = st.out_enable[0] && !ext_mode_on && internal_trig;
        next_st.term_en = st.termination[0];
        // Write address and data are taken in either order
        if (aw_take)
        begin
            next_st.aw_addr = axi_req.awaddr;
            next_st.aw_held = 1'b1;
            next_st.rsp.awready = 1'b0;
        end
        if (w_take)
        begin
            next_st.w_data = axi_req.wdata;
            next_st.w_strb = axi_req.wstrb;
            next_st.w_held = 1'b1;
            next_st.rsp.wready = 1'b0;
        end
        // Both halves present: perform the write and answer
        if (have_aw && have_w && !st.rsp.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.awready = 1'b0;
            next_st.rsp.wready = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = RESP_OKAY;
            if (wr_idx == IDX_OUT_EN)
            begin
                next_st.out_enable = ttd_merge(st.out_enable, wr_data, wr_strb);
            end
            else if (wr_idx == IDX_TERM)
            begin
                next_st.termination = ttd_merge(st.termination, wr_data, wr_strb);
            end
            else if (wr_idx == IDX_OR_MASK)
            begin
                next_st.or_mask = ttd_merge(st.or_mask, wr_data, wr_strb);
            end
            else if (wr_idx == IDX_MAIN_MODE)
            begin
                if (ttd_mode_ok(ttd_merge(st.main_mode, wr_data, wr_strb), avail_modes))
                begin
                    next_st.main_mode = ttd_merge(st.main_mode, wr_data, wr_strb);
                end
                else
                begin
                    next_st.rsp.bresp = RESP_SLVERR;
                end
            end
            else if (wr_idx == IDX_EXTRA0_MODE && EXTRA_IN_FITTED)
            begin
                if (ttd_mode_ok(ttd_merge(st.extra0_mode, wr_data, wr_strb), avail_modes))
                begin
                    next_st.extra0_mode = ttd_merge(st.extra0_mode, wr_data, wr_strb);
                end
                else
                begin
                    next_st.rsp.bresp = RESP_SLVERR;
                end
            end
            else if (wr_idx == IDX_EXTRA1_MODE && EXTRA_IN_FITTED)
            begin
                if (ttd_mode_ok(ttd_merge(st.extra1_mode, wr_data, wr_strb), avail_modes))
                begin
                    next_st.extra1_mode = ttd_merge(st.extra1_mode, wr_data, wr_strb);
                end
                else
                begin
                    next_st.rsp.bresp = RESP_SLVERR;
                end
            end
            else
            begin
                next_st.rsp.bresp = RESP_SLVERR;
            end
        end
        // Write response taken: reopen both write channels
        if (st.rsp.bvalid && axi_req.bready)
        begin
            next_st.rsp.bvalid = 1'b0;
            next_st.rsp.awready = 1'b1;
            next_st.rsp.wready = 1'b1;
        end
        // Read: decode and answer at the edge after the address is taken
        if (ar_take)
        begin
            next_st.rsp.arready = 1'b0;
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp = RESP_OKAY;
            next_st.rsp.rdata = 32'h0;
            if (rd_idx == IDX_OUT_EN)
            begin
                next_st.rsp.rdata = st.out_enable;
            end
            else if (rd_idx == IDX_TERM)
            begin
                next_st.rsp.rdata = st.termination;
            end
            else if (rd_idx == IDX_OR_MASK)
            begin
                next_st.rsp.rdata = st.or_mask;
            end
            else if (rd_idx == IDX_AVAIL_MODES)
            begin
                next_st.rsp.rdata = avail_modes;
            end
            else if (rd_idx == IDX_MAIN_MODE)
            begin
                next_st.rsp.rdata = st.main_mode;
            end
            else if (rd_idx == IDX_STATUS)
            begin
                next_st.rsp.rdata = {29'h0, ext_mode_on, st.trig, st.armed};
            end
            else if (rd_idx == IDX_EXTRA0_MODE && EXTRA_IN_FITTED)
            begin
                next_st.rsp.rdata = st.extra0_mode;
            end
            else if (rd_idx == IDX_EXTRA1_MODE && EXTRA_IN_FITTED)
            begin
                next_st.rsp.rdata = st.extra1_mode;
            end
            else
            begin
                next_st.rsp.rresp = RESP_SLVERR;
            end
        end
        else if (st.rsp.rvalid && axi_req.rready)
        begin
            next_st.rsp.rvalid = 1'b0;
            next_st.rsp.arready = 1'b1;
        end
    end

    // State register; bus channels open after reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.out_enable <= REG_RESET;
            st.termination <= REG_RESET;
            st.or_mask <= REG_RESET;
            st.main_mode <= REG_RESET;
            st.extra0_mode <= REG_RESET;
            st.extra1_mode <= REG_RESET;
            st.rsp.awready <= 1'b1;
            st.rsp.wready <= 1'b1;
            st.rsp.arready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from state flip-flops
    assign axi_rsp = st.rsp;
    assign trig_conn_out = st.conn_out;
    assign trig_conn_oe = st.conn_oe;
    assign term_50_en = st.term_en;
    assign trig_pulse = st.trig;
    assign armed = st.armed;
endmodule : ttd_top

// *** ttd_pkg.sv ***
/*
 Constants, register indices and bus carriers of the external TTL trigger detector.
 Assumes one 25 MHz sampling clock and an AXI4-Lite master of 32-bit data.
*/
// Contract
// - Or-mask value 2h enables main external input
// - Or-mask value 100h enables extra input 0
// - Or-mask value 200h enables extra input 1
// - External mode forces connector into input use
// - Output enable drives connector only without external mode
// - Termination 1 selects 50 Ohm, 0 high impedance
// - Mode 1h fires on first rising edge
// - After trigger, ignore conditions until armed again
// - Mode 10000001h stretches HIGH pulses, then fires
// - Stretching lets edges catch very short pulses
// - Read-only mask reports the supported modes
// - Mode 8h fires on first HIGH level
// - Level already present at start fires immediately
// - Mode 2h fires on first falling edge
// - Mode 10000002h stretches LOW pulses, then fires
// - Mode 10h fires on first LOW level
// - Mode 4h fires on first edge either way
// - Mode 0h removes the input from detection
// - Each extra input has its own mode register
package ttd_pkg;
    localparam int CLK_NS = 40;
    localparam int STRETCH_NS = 100;
    localparam logic [3:0] STRETCH_CYC = 4'((STRETCH_NS + CLK_NS - 1) / CLK_NS);
    localparam int ADDR_W = 20;
    localparam int IDX_W = 18;
    localparam logic [IDX_W-1:0] IDX_OUT_EN = 18'd40100;
    localparam logic [IDX_W-1:0] IDX_TERM = 18'd40110;
    localparam logic [IDX_W-1:0] IDX_OR_MASK = 18'd40410;
    localparam logic [IDX_W-1:0] IDX_AVAIL_MODES = 18'd40500;
    localparam logic [IDX_W-1:0] IDX_MAIN_MODE = 18'd40510;
    localparam logic [IDX_W-1:0] IDX_STATUS = 18'd40520;
    localparam logic [IDX_W-1:0] IDX_EXTRA0_MODE = 18'd40560;
    localparam logic [IDX_W-1:0] IDX_EXTRA1_MODE = 18'd40561;
    localparam int MASK_MAIN_BIT = 1;
    localparam int MASK_EXTRA0_BIT = 8;
    localparam int MASK_EXTRA1_BIT = 9;
    localparam logic [31:0] OR_MASK_MAIN = 32'h0000_0002;
    localparam logic [31:0] OR_MASK_EXTRA0 = 32'h0000_0100;
    localparam logic [31:0] OR_MASK_EXTRA1 = 32'h0000_0200;
    localparam logic [31:0] INPUT_UNUSED_MODE = 32'h0000_0000;
    localparam logic [31:0] RISING_EDGE_MODE = 32'h0000_0001;
    localparam logic [31:0] FALLING_EDGE_MODE = 32'h0000_0002;
    localparam logic [31:0] ANY_EDGE_MODE = 32'h0000_0004;
    localparam logic [31:0] HIGH_LEVEL_MODE = 32'h0000_0008;
    localparam logic [31:0] LOW_LEVEL_MODE = 32'h0000_0010;
    localparam logic [31:0] PULSE_STRETCH_FLAG = 32'h1000_0000;
    localparam logic STRETCH_FITTED = 1'b1;
    localparam logic EXTRA_IN_FITTED = 1'b1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } ttd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ttd_axi_rsp_t;
endpackage : ttd_pkg

// *** ttd_in_det.sv ***
/*
 One TTL input detector: synchroniser, filter, optional stretch, edge and level match.
 Assumes the pin is asynchronous and that the caller registers the hit.
*/
module ttd_in_det
    import ttd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic [31:0] mode,
    input wire logic armed,
    output logic hit
);
    typedef struct packed {
        logic [2:0] sync;
        logic filt;
        logic view;
        logic prev_view;
        logic [3:0] stretch_cnt;
    } ttd_det_state_t;

    ttd_det_state_t st;
    ttd_det_state_t next_st;
    logic stretch_on;
    logic act_level;
    logic rise;
    logic fall;
    logic [31:0] base_mode;

    // Split the mode into its base encoding and the stretch flag
    assign stretch_on = STRETCH_FITTED && ((mode & PULSE_STRETCH_FLAG) != 32'h0);
    assign base_mode = mode & ~PULSE_STRETCH_FLAG;
    assign act_level = (base_mode != FALLING_EDGE_MODE);
    assign rise = st.view & ~st.prev_view;
    assign fall = ~st.view & st.prev_view;

    // Next state: shift synchroniser, accept a change once stages two and three agree
    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[1:0], pin};
        if (st.sync[1] == st.sync[2])
        begin
            next_st.filt = st.sync[2];
        end
        next_st.prev_view = st.view;
        next_st.view = st.filt;
        // Stretch: one sample of the active level at stage three restarts the hold,
        // so a pulse too short for the two-stage agreement still forms a clean edge
        if (stretch_on && (st.sync[2] == act_level))
        begin
            next_st.stretch_cnt = STRETCH_CYC;
        end
        else if (st.stretch_cnt != 4'h0)
        begin
            next_st.stretch_cnt = st.stretch_cnt - 4'h1;
        end
        if (stretch_on && (st.stretch_cnt != 4'h0))
        begin
            next_st.view = act_level;
        end
    end

    // Match the selected condition while armed
    always_comb
    begin
        hit = 1'b0;
        if (armed)
        begin
            case (base_mode)
                RISING_EDGE_MODE: hit = rise;
                FALLING_EDGE_MODE: hit = fall;
                ANY_EDGE_MODE: hit = rise | fall;
                HIGH_LEVEL_MODE: hit = st.view;
                LOW_LEVEL_MODE: hit = ~st.view;
                default: hit = 1'b0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule : ttd_in_det

// *** ttd_checker.sv ***
/*
 Port assertions for the TTL trigger detector top.
 Assumes one clock with active-low reset; bound to ttd_top below.
*/
module ttd_checker
    import ttd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ttd_axi_req_t axi_req,
    input wire ttd_axi_rsp_t axi_rsp,
    input wire logic trig_conn_out,
    input wire logic trig_conn_oe,
    input wire logic acq_arm,
    input wire logic internal_trig,
    input wire logic trig_pulse,
    input wire logic armed
);
    // Every check runs on the sampling clock
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Trigger pulse, arming and disarming
    a_pulse_single: assert property (trig_pulse |=> !trig_pulse)
        else $error("trigger pulse held over one cycle");
    a_pulse_disarms: assert property (trig_pulse |-> !armed && $past(armed))
        else $error("trigger pulse without disarm");
    a_quiet_disarmed: assert property (!armed |=> !trig_pulse)
        else $error("trigger fired while disarmed");
    a_arm_next: assert property (acq_arm && !armed |=> armed)
        else $error("arm request not taken");

    // Connector mirrors the internal trigger only while driven
    a_out_mirror: assert property (trig_conn_oe |-> trig_conn_out == $past(internal_trig))
        else $error("connector drive does not follow internal trigger");
    a_out_quiet: assert property (!trig_conn_oe |-> !trig_conn_out)
        else $error("connector value while not driven");

    // Register bus answers one cycle after the handshake
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |=> axi_rsp.bvalid)
        else $error("write answer late");
    a_read_refuse: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while answer pending");
endmodule : ttd_checker

bind ttd_top ttd_checker i_chk (.clk, .rst_b, .axi_req, .axi_rsp, .trig_conn_out,
    .trig_conn_oe, .acq_arm, .internal_trig, .trig_pulse, .armed);

// *** ttd_src_model.sv ***
/*
 External TTL source for the main connector and the two extra inputs.
 Assumes calls come just after a clock edge; changes land off the edge.
*/
module ttd_src_model
(
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // A TTL source always drives, idle low
    initial pin = 3'b000;

    // Level change, asynchronous to the sampling clock
    task automatic set(input int i, input logic v);
        fork
            #13 pin[i] = v;
        join_none
    endtask : set

    // Pulse of w ns, may be shorter than a sample period
    task automatic pulse(input int i, input logic v, input int w);
        fork
            begin
                #7 pin[i] = v;
                #(w) pin[i] = ~v;
            end
        join_none
    endtask : pulse
endmodule : ttd_src_model

// *** ttd_top_test.sv ***
/*
 Self-checking bench of the TTL trigger detector.
 Assumes ttd_checker is bound and ttd_src_model drives the pins.
*/
module ttd_top_test
    import ttd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ttd_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
    ttd_axi_rsp_t rsp;
    logic [2:0] pin;
    logic acq_arm = 1'b0;
    logic itrig = 1'b0;
    logic trig_pulse, armed, c_out, c_oe, term;
    wire logic conn = c_oe ? c_out : pin[0];
    logic [35:0] q[$];
    int errors = 0;
    int total_checks = 0;
    int seed = 32'h4c31c99f;
    logic [31:0] modes [7] = '{RISING_EDGE_MODE, FALLING_EDGE_MODE, ANY_EDGE_MODE,
        HIGH_LEVEL_MODE, LOW_LEVEL_MODE, PULSE_STRETCH_FLAG | RISING_EDGE_MODE,
        PULSE_STRETCH_FLAG | FALLING_EDGE_MODE};
    logic [6:0] idle = 7'b1001010;
    logic [31:0] masks [3] = '{OR_MASK_MAIN, OR_MASK_EXTRA0, OR_MASK_EXTRA1};
    logic [17:0] idxs [7] = '{IDX_OUT_EN, IDX_TERM, IDX_OR_MASK, IDX_MAIN_MODE,
        IDX_EXTRA0_MODE, IDX_EXTRA1_MODE, IDX_AVAIL_MODES};

    always #20 clk = ~clk;

    ttd_top i_dut (.clk(clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
        .trig_conn_in(conn), .trig_conn_out(c_out), .trig_conn_oe(c_oe),
        .extra_in0(pin[1]), .extra_in1(pin[2]), .term_50_en(term), .acq_arm(acq_arm),
        .internal_trig(itrig), .trig_pulse(trig_pulse), .armed(armed));
    ttd_src_model i_src (.pin(pin));

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic fail(input logic [35:0] g, input logic [35:0] e);
        errors++;
        $display("unexpected at %0t got %h expected %h", $time, g, e);
    endtask : fail

    // Oldest note against a result; all ones means nothing was noted
    task automatic chk(input logic [35:0] g);
        logic [35:0] e;
        e = (q.size() > 0) ? q.pop_front() : '1;
        total_checks++;
        if (g !== e) fail(g, e);
    endtask : chk

    task automatic lvl(input logic g, input logic e);
        total_checks++;
        if (g !== e) fail(36'(g), 36'(e));
    endtask : lvl

    task automatic tmo(input int n);
        if (n < 20)
            return;
        errors++;
        print_verdict;
    endtask : tmo

    // Results as they appear: read data, write response, trigger
    always @(posedge clk)
    begin
        if (rst_b && rsp.rvalid && req.rready) chk({2'd0, rsp.rresp, rsp.rdata});
        if (rst_b && rsp.bvalid && req.bready) chk({2'd1, 32'h0, rsp.bresp});
        if (rst_b && trig_pulse) chk({2'd2, 34'h0});
    end

    // Bus write; ready signals sampled at the edge, release after
    task automatic wr(input logic [17:0] i, input logic [31:0] d, input logic [1:0] r);
        int n;
        q.push_back({2'd1, 32'h0, r});
        req.awaddr <= {i, 2'b00};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        tmo(n);
    endtask : wr

    task automatic rd(input logic [17:0] i, input logic [31:0] d, input logic [1:0] r);
        int n;
        q.push_back({2'd0, r, d});
        req.araddr <= {i, 2'b00};
        req.arvalid <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        tmo(n);
    endtask : rd

    task automatic arm;
        acq_arm <= 1'b1;
        @(posedge clk);
        acq_arm <= 1'b0;
    endtask : arm

    // A trigger is expected or not within a bounded window
    task automatic expect_trig(input logic e);
        if (e) q.push_back({2'd2, 34'h0});
        repeat (14) @(posedge clk);
        lvl(q.size() == 0, 1'b1);
    endtask : expect_trig

    initial
    begin
        int k;
        int m;
        int j;
        logic s;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // Reset values, supported modes, an unmapped place
        for (k = 0; k < 7; k++)
            rd(idxs[k], (k == 6) ? 32'h1000_001f : REG_RESET, RESP_OKAY);
        rd(18'd40111, 32'h0, RESP_SLVERR);
        wr(18'd40111, 32'h1, RESP_SLVERR);
        // Termination pin follows the register
        for (k = 1; k >= 0; k--)
        begin
            wr(IDX_TERM, 32'(k), RESP_OKAY);
            @(posedge clk);
            lvl(term, k[0]);
        end
        // Main input in every mode, then quiet until armed again
        wr(IDX_OR_MASK, OR_MASK_MAIN, RESP_OKAY);
        for (k = 0; k < 7; k++)
        begin
            s = (k == 2) ? 1'($random(seed)) : idle[k];
            i_src.set(0, s);
            wr(IDX_MAIN_MODE, modes[k], RESP_OKAY);
            repeat (10) @(posedge clk);
            arm;
            if (k >= 5) i_src.pulse(0, ~s, 35);
            else if (k < 3) i_src.set(0, ~s);
            expect_trig(1'b1);
            i_src.pulse(0, ~pin[0], 200);
            expect_trig(1'b0);
        end
        // Mask picks the source; extra inputs have modes of their own
        i_src.set(0, 1'b0);
        wr(IDX_EXTRA0_MODE, RISING_EDGE_MODE, RESP_OKAY);
        wr(IDX_EXTRA1_MODE, RISING_EDGE_MODE, RESP_OKAY);
        wr(IDX_MAIN_MODE, RISING_EDGE_MODE, RESP_OKAY);
        for (m = 0; m < 3; m++)
        begin
            wr(IDX_OR_MASK, masks[m], RESP_OKAY);
            for (j = 0; j < 3; j++)
            begin
                arm;
                i_src.pulse(j, 1'b1, 200);
                expect_trig(m == j);
            end
        end
        // Unused mode removes the input even when masked in
        wr(IDX_OR_MASK, OR_MASK_MAIN, RESP_OKAY);
        wr(IDX_MAIN_MODE, INPUT_UNUSED_MODE, RESP_OKAY);
        arm;
        i_src.pulse(0, 1'b1, 200);
        expect_trig(1'b0);
        // Connector driven only without an external mode
        wr(IDX_OUT_EN, 32'h1, RESP_OKAY);
        @(posedge clk);
        lvl(c_oe, 1'b1);
        for (k = 0; k < 12; k++)
        begin
            itrig <= 1'($random(seed));
            @(posedge clk);
        end
        itrig <= 1'b0;
        repeat (8) @(posedge clk);
        wr(IDX_MAIN_MODE, FALLING_EDGE_MODE, RESP_OKAY);
        @(posedge clk);
        lvl(c_oe, 1'b0);
        // Unsupported mode refused, old mode kept
        wr(IDX_MAIN_MODE, PULSE_STRETCH_FLAG | HIGH_LEVEL_MODE, RESP_SLVERR);
        rd(IDX_MAIN_MODE, FALLING_EDGE_MODE, RESP_OKAY);
        repeat (8) @(posedge clk);
        lvl(q.size() == 0, 1'b1);
        print_verdict;
    end
endmodule : ttd_top_test
